// ---- design/t1_sig_pkg.sv ----
// Package: register map, field layout and line-side carriers of the framer control block
package t1_sig_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] CTL_IDX = 8'h1e;
  localparam logic [7:0] MON_IDX = 8'h1f;
  localparam logic [7:0] SIGCTL_IDX = 8'h20;
  localparam logic [7:0] RS_BASE_IDX = 8'h60;
  localparam logic [7:0] TS_BASE_IDX = 8'h70;
  localparam int SIG_REGS = 12;
  localparam int SIG_BITS = SIG_REGS * 8;
  // Field positions
  localparam int CRC_SEL_BIT = 7;
  localparam int RX_ALIGN_BIT = 6;
  localparam int TX_ALIGN_BIT = 5;
  localparam int MON_MSB = 4;
  localparam int MON_LSB = 0;
  localparam int FORCE_ONES_BIT = 5;
  localparam logic [2:0] LAST_BIT_IDX = 3'h7;
  // Reset values
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [7:0] SIGCTL_RST = 8'h00;
  localparam logic [7:0] MON_RST = 8'h00;

  typedef struct packed {
    logic data;
    logic bit_en;
    logic [4:0] chan;
    logic [2:0] bit_idx;
    logic sig_pos;
    logic [1:0] sig_sel;
    logic mf_boundary;
    logic loss_sync;
  } rx_line_s;

  typedef struct packed {
    logic data;
    logic bit_en;
    logic [4:0] chan;
    logic sig_pos;
    logic [1:0] sig_sel;
    logic mf_boundary;
  } tx_line_s;
endpackage : t1_sig_pkg

// ---- design/align_edge_arm.sv ----
// One-shot elastic store align request from a rising control bit
`timescale 1ns/10ps
`default_nettype none
module align_edge_arm (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic align_bit,
  input wire logic sep_gt_half,
  output logic align_pulse
);
  logic prev_reg;
  logic prev_next;
  logic pulse_reg;
  logic pulse_next;

  always_comb begin
    prev_next = align_bit;
    // Held-high bit fires nothing; a wide gap is left alone
    pulse_next = align_bit && !prev_reg && !sep_gt_half;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_reg <= 1'b0;
      pulse_reg <= 1'b0;
    end else begin
      prev_reg <= prev_next;
      pulse_reg <= pulse_next;
    end
  end

  assign align_pulse = pulse_reg;

  align_fire_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(align_bit) && !sep_gt_half |=> align_pulse)
    else $error("align request not issued on rising bit");
  align_wide_a: assert property (@(posedge pclk) disable iff (!presetn)
    sep_gt_half |=> !align_pulse)
    else $error("align issued while separation already wide");
  align_once_a: assert property (@(posedge pclk) disable iff (!presetn)
    align_pulse |=> !align_pulse ##1 (!align_pulse || $past(!align_bit, 2)))
    else $error("align fired again without bit toggling");
  align_cov_c: cover property (@(posedge pclk) disable iff (!presetn) align_pulse);
endmodule : align_edge_arm
`default_nettype wire

// ---- design/t1_rx_monitor_align_signaling_ctl.sv ----
// Framer control: CRC6 select, elastic align, DS0 monitor, robbed-bit signaling
//
// Behaviour
// - CRC6 select bit picks standard or alternate
// - Receive align rise forces half-frame separation
// - Already wide separation leaves pointers alone
// - Align fires only on rising bit edge
// - Transmit align rise forces half-frame separation
// - Five-bit field selects monitored receive timeslot
// - First received bit lands in bit 7
// - Force-ones clear passes signaling bits unchanged
// - Force-ones set drives signaling positions of the receive serial output high
// - Twelve receive, twelve transmit signaling registers
// - Extract receive, insert transmit robbed-bit signaling
// - Processor and hardware signaling work together
`timescale 1ns/10ps
`default_nettype none
module t1_rx_monitor_align_signaling_ctl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire t1_sig_pkg::rx_line_s rx_line,
  input wire t1_sig_pkg::tx_line_s tx_line,
  input wire logic rx_es_sep_gt_half,
  input wire logic tx_es_sep_gt_half,
  output logic rx_alt_crc6_select,
  output logic rx_es_align,
  output logic tx_es_align,
  output logic rx_serial_output,
  output logic rx_sig_hw_out,
  output logic tx_serial_out
);
  import t1_sig_pkg::*;

  // ******************************************
  // Helpers
  // ******************************************
  // Flat bit of a channel/bit-letter pair in the twelve-register block
  function automatic logic [6:0] sig_index(input logic [4:0] chan, input logic [1:0] sel);
    logic [6:0] reg_no;
    reg_no = 7'(sel) * 7'd3 + 7'(chan[4:3]);
    return {reg_no[3:0], chan[2:0]};
  endfunction : sig_index

  // True when a bus address decodes to the given register index
  function automatic logic idx_hit(input logic [11:0] addr, input logic [7:0] idx);
    return addr[9:2] == idx && addr[11:10] == 2'b00;
  endfunction : idx_hit

  function automatic logic sig_hit(input logic [11:0] addr, input logic [7:0] base);
    return addr[11:10] == 2'b00 && addr[9:2] >= base &&
      addr[9:2] < base + 8'(SIG_REGS);
  endfunction : sig_hit

  // ******************************************
  // Register bus
  // ******************************************
  logic [7:0] ctl_reg;
  logic [7:0] ctl_next;
  logic [7:0] sigctl_reg;
  logic [7:0] sigctl_next;
  logic [SIG_BITS-1:0] ts_reg;
  logic [SIG_BITS-1:0] ts_next;
  logic [SIG_BITS-1:0] rs_reg;
  logic [SIG_BITS-1:0] rs_next;
  logic [7:0] mon_reg;
  logic [7:0] mon_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic setup;
  logic access;
  logic mapped;
  logic [3:0] rs_slot;
  logic [3:0] ts_slot;

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign mapped = idx_hit(paddr, CTL_IDX) || idx_hit(paddr, MON_IDX) ||
    idx_hit(paddr, SIGCTL_IDX) || sig_hit(paddr, RS_BASE_IDX) || sig_hit(paddr, TS_BASE_IDX);
  assign rs_slot = 4'(paddr[9:2] - RS_BASE_IDX);
  assign ts_slot = 4'(paddr[9:2] - TS_BASE_IDX);
  // No wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata = prdata_reg;

  always_comb begin
    ctl_next = ctl_reg;
    sigctl_next = sigctl_reg;
    ts_next = ts_reg;
    prdata_next = prdata_reg;
    if (access && pwrite) begin
      if (idx_hit(paddr, CTL_IDX)) begin
        ctl_next = pwdata[7:0];
      end
      if (idx_hit(paddr, SIGCTL_IDX)) begin
        sigctl_next = pwdata[7:0];
      end
      if (sig_hit(paddr, TS_BASE_IDX)) begin
        ts_next[ts_slot*8 +: 8] = pwdata[7:0];
      end
    end
    // Read data sampled in setup so it leaves a flip-flop during access
    if (setup && !pwrite) begin
      prdata_next = 32'h0000_0000;
      if (idx_hit(paddr, CTL_IDX)) begin
        prdata_next[7:0] = ctl_reg;
      end
      if (idx_hit(paddr, MON_IDX)) begin
        prdata_next[7:0] = mon_reg;
      end
      if (idx_hit(paddr, SIGCTL_IDX)) begin
        prdata_next[7:0] = sigctl_reg;
      end
      if (sig_hit(paddr, RS_BASE_IDX)) begin
        prdata_next[7:0] = rs_reg[rs_slot*8 +: 8];
      end
      if (sig_hit(paddr, TS_BASE_IDX)) begin
        prdata_next[7:0] = ts_reg[ts_slot*8 +: 8];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_reg <= CTL_RST;
      sigctl_reg <= SIGCTL_RST;
      ts_reg <= '0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      ctl_reg <= ctl_next;
      sigctl_reg <= sigctl_next;
      ts_reg <= ts_next;
      prdata_reg <= prdata_next;
    end
  end

  assign rx_alt_crc6_select = ctl_reg[CRC_SEL_BIT];

  // ******************************************
  // Elastic store align
  // ******************************************
  // Clock stability before arming is left to software
  align_edge_arm rx_arm (
    .pclk(pclk),
    .presetn(presetn),
    .align_bit(ctl_reg[RX_ALIGN_BIT]),
    .sep_gt_half(rx_es_sep_gt_half),
    .align_pulse(rx_es_align)
  );

  align_edge_arm tx_arm (
    .pclk(pclk),
    .presetn(presetn),
    .align_bit(ctl_reg[TX_ALIGN_BIT]),
    .sep_gt_half(tx_es_sep_gt_half),
    .align_pulse(tx_es_align)
  );

  // ******************************************
  // Receive DS0 monitor
  // ******************************************
  logic [7:0] mon_shift_reg;
  logic [7:0] mon_shift_next;
  logic mon_take;

  // Field holds channel minus one, so it compares straight to the timeslot
  assign mon_take = rx_line.bit_en && rx_line.chan == ctl_reg[MON_MSB:MON_LSB];

  always_comb begin
    mon_shift_next = mon_shift_reg;
    mon_next = mon_reg;
    if (mon_take) begin
      mon_shift_next = {mon_shift_reg[6:0], rx_line.data};
      if (rx_line.bit_idx == LAST_BIT_IDX) begin
        mon_next = {mon_shift_reg[6:0], rx_line.data};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mon_shift_reg <= 8'h00;
      mon_reg <= MON_RST;
    end else begin
      mon_shift_reg <= mon_shift_next;
      mon_reg <= mon_next;
    end
  end

  // ******************************************
  // Robbed-bit signaling
  // ******************************************
  logic [SIG_BITS-1:0] rs_shadow_reg;
  logic [SIG_BITS-1:0] rs_shadow_next;
  logic [SIG_BITS-1:0] ts_shift_reg;
  logic [SIG_BITS-1:0] ts_shift_next;
  logic rx_ser_reg;
  logic rx_ser_next;
  logic rx_hw_reg;
  logic rx_hw_next;
  logic tx_ser_reg;
  logic tx_ser_next;
  logic force_ones;

  assign force_ones = sigctl_reg[FORCE_ONES_BIT];

  always_comb begin
    rs_shadow_next = rs_shadow_reg;
    rs_next = rs_reg;
    rx_ser_next = rx_ser_reg;
    rx_hw_next = rx_hw_reg;
    if (rx_line.bit_en) begin
      rx_ser_next = rx_line.data;
      if (rx_line.sig_pos) begin
        rs_shadow_next[sig_index(rx_line.chan, rx_line.sig_sel)] = rx_line.data;
        if (force_ones) begin
          rx_ser_next = 1'b1;
        end
      end
      // Hardware path reads the held block, independent of processor reads
      rx_hw_next = rs_reg[sig_index(rx_line.chan, rx_line.sig_sel)];
    end
    // Frozen while out of sync so the last good signaling survives
    if (rx_line.mf_boundary && !rx_line.loss_sync) begin
      rs_next = rs_shadow_reg;
    end
  end

  always_comb begin
    ts_shift_next = ts_shift_reg;
    tx_ser_next = tx_ser_reg;
    if (tx_line.mf_boundary) begin
      ts_shift_next = ts_reg;
    end
    if (tx_line.bit_en) begin
      tx_ser_next = tx_line.sig_pos ?
        ts_shift_reg[sig_index(tx_line.chan, tx_line.sig_sel)] : tx_line.data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rs_shadow_reg <= '0;
      rs_reg <= '0;
      ts_shift_reg <= '0;
      rx_ser_reg <= 1'b0;
      rx_hw_reg <= 1'b0;
      tx_ser_reg <= 1'b0;
    end else begin
      rs_shadow_reg <= rs_shadow_next;
      rs_reg <= rs_next;
      ts_shift_reg <= ts_shift_next;
      rx_ser_reg <= rx_ser_next;
      rx_hw_reg <= rx_hw_next;
      tx_ser_reg <= tx_ser_next;
    end
  end

  assign rx_serial_output = rx_ser_reg;
  assign rx_sig_hw_out = rx_hw_reg;
  assign tx_serial_out = tx_ser_reg;

  // ******************************************
  // Checks
  // ******************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  crc_select_a: assert property (
    access && pwrite && idx_hit(paddr, CTL_IDX) |=> rx_alt_crc6_select == $past(pwdata[7]))
    else $error("CRC6 select does not follow written bit");
  monitor_order_a: assert property (
    mon_take && rx_line.bit_idx == LAST_BIT_IDX |=>
      mon_reg == {$past(mon_shift_reg[6:0]), $past(rx_line.data)})
    else $error("monitor byte not refreshed in bit order");
  monitor_hold_a: assert property (
    !(mon_take && rx_line.bit_idx == LAST_BIT_IDX) |=> $stable(mon_reg))
    else $error("monitor byte changed mid frame");
  sig_pass_a: assert property (
    rx_line.bit_en && !(rx_line.sig_pos && force_ones) |=>
      rx_serial_output == $past(rx_line.data))
    else $error("receive bit not passed through");
  force_ones_a: assert property (
    rx_line.bit_en && rx_line.sig_pos && force_ones |=> rx_serial_output)
    else $error("signaling position not forced high");
  rs_freeze_a: assert property (
    rx_line.mf_boundary && rx_line.loss_sync |=> $stable(rs_reg))
    else $error("signaling updated while out of sync");
  tx_insert_a: assert property (
    tx_line.bit_en && tx_line.sig_pos |=>
      tx_serial_out == $past(ts_shift_reg[sig_index(tx_line.chan, tx_line.sig_sel)]))
    else $error("transmit signaling not inserted");
  ts_write_a: assert property (
    access && pwrite && sig_hit(paddr, TS_BASE_IDX) |=>
      ts_reg[$past(ts_slot)*8 +: 8] == $past(pwdata[7:0]))
    else $error("transmit signaling register not written");
  unmapped_a: assert property (access && !mapped |-> pslverr && pready)
    else $error("unmapped access not flagged");

  mon_cov_c: cover property (mon_take && rx_line.bit_idx == LAST_BIT_IDX);
  force_cov_c: cover property (rx_line.bit_en && rx_line.sig_pos && force_ones);
  mf_cov_c: cover property (rx_line.mf_boundary && !rx_line.loss_sync);
  tx_cov_c: cover property (tx_line.bit_en && tx_line.sig_pos);
endmodule : t1_rx_monitor_align_signaling_ctl
`default_nettype wire

// ---- tb/t1_line_model.sv ----
// Far-side line model: one T1 frame of receive and transmit bits per start pulse
`timescale 1ns/10ps
`default_nettype none
module t1_line_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic [7:0] pat,
  input wire logic lost,
  output var t1_sig_pkg::rx_line_s rx_line,
  output var t1_sig_pkg::tx_line_s tx_line
);
  import t1_sig_pkg::*;
  logic [7:0] cnt_reg, slot_byte;
  logic run_reg, tog_reg, en;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 8'h00;
      run_reg <= 1'b0;
      tog_reg <= 1'b0;
    end else begin
      tog_reg <= ~tog_reg;
      if (run_reg) begin
        cnt_reg <= cnt_reg + 8'h01;
        run_reg <= cnt_reg != 8'hc0;
      end else if (go) begin
        cnt_reg <= 8'h00;
        run_reg <= 1'b1;
      end
    end
  end
  // Slots 0..23 stand for channels 1..24; data toggles when no bit is valid
  always_comb begin
    en = run_reg && (cnt_reg < 8'hc0);
    slot_byte = pat ^ {3'h0, cnt_reg[7:3]};
    rx_line = '0;
    rx_line.bit_en = en;
    rx_line.chan = cnt_reg[7:3];
    rx_line.bit_idx = cnt_reg[2:0];
    rx_line.data = en ? slot_byte[3'h7 - cnt_reg[2:0]] : tog_reg;
    rx_line.sig_pos = en && (cnt_reg[2:0] == 3'h7);
    rx_line.mf_boundary = run_reg && (cnt_reg == 8'hc0);
    rx_line.loss_sync = lost;
    tx_line = '0;
    tx_line.data = rx_line.data;
    tx_line.bit_en = en;
    tx_line.chan = rx_line.chan;
    tx_line.sig_pos = rx_line.sig_pos;
    tx_line.mf_boundary = rx_line.mf_boundary;
  end
endmodule : t1_line_model
`default_nettype wire

// ---- tb/tb_t1_rx_monitor_align_signaling_ctl.sv ----
// Self-checking bench for the framer control block
`timescale 1ns/10ps
`default_nettype none
module tb_t1_rx_monitor_align_signaling_ctl;
  import t1_sig_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  rx_line_s rx_line;
  tx_line_s tx_line;
  logic go, sep_r, sep_t, force_q, crc, rx_al, tx_al, rx_ser, tx_ser, rx_hw, lost;
  logic prev_en = 1'b0, prev_exp = 1'b0, prev_tx = 1'b0, prev_hw = 1'b0;
  logic [7:0] pat, mon_exp;
  // Mirrors of what software wrote and of the held receive signaling
  logic [23:0] ts_live = 24'h000000, ts_held = 24'h000000;
  logic [7:0] rs_exp = 8'h00;
  integer seed = 32'h89ea9717;
  int mismatches = 0;
  int checks = 0;
  int rxp = 0;
  int txp = 0;

  t1_rx_monitor_align_signaling_ctl uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_line(rx_line), .tx_line(tx_line),
    .rx_es_sep_gt_half(sep_r), .tx_es_sep_gt_half(sep_t), .rx_alt_crc6_select(crc),
    .rx_es_align(rx_al), .tx_es_align(tx_al), .rx_serial_output(rx_ser),
    .rx_sig_hw_out(rx_hw), .tx_serial_out(tx_ser));
  t1_line_model model (.pclk(pclk), .presetn(presetn), .go(go), .pat(pat), .lost(lost),
    .rx_line(rx_line), .tx_line(tx_line));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ****************
  // Line and pulse watch
  // ****************
  always @(posedge pclk) begin
    if (rx_al === 1'b1) rxp++;
    if (tx_al === 1'b1) txp++;
    if (prev_en === 1'b1) begin
      chk(32'(rx_ser), 32'(prev_exp));
      chk(32'(tx_ser), 32'(prev_tx));
      if (!force_q) chk(32'(rx_hw), 32'(prev_hw));
    end
    prev_en <= rx_line.bit_en;
    prev_exp <= rx_line.data | (rx_line.sig_pos & force_q);
    prev_tx <= tx_line.sig_pos ? ts_held[tx_line.chan] : tx_line.data;
    prev_hw <= rs_exp[rx_line.chan[2:0]];
    if (tx_line.mf_boundary) ts_held <= ts_live;
    // Letter A of channel c lands in bit c%8; only the low bit of the slot counts
    if (rx_line.mf_boundary && !rx_line.loss_sync) rs_exp <= pat[0] ? 8'h55 : 8'haa;
  end

  // ****************
  // Tasks
  // ****************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                     output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic ee);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, d, r, e);
    chk(32'(e), 32'(ee));
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] x, input logic ee);
    logic [31:0] r;
    logic e;
    apb(1'b0, idx, 8'h00, r, e);
    chk(r, {24'h0, x});
    chk(32'(e), 32'(ee));
  endtask : rd

  task automatic align(input logic [7:0] v, input logic sr, input logic st,
                       input int er, input int et);
    int r0, t0;
    sep_r <= sr;
    sep_t <= st;
    r0 = rxp;
    t0 = txp;
    // Only raised once the clock has long been running
    wr(CTL_IDX, v, 1'b0);
    repeat (4) @(posedge pclk);
    chk(32'(rxp - r0), 32'(er));
    chk(32'(txp - t0), 32'(et));
  endtask : align

  task automatic frame(input logic [4:0] ch, input logic f, input logic l);
    logic c;
    logic [7:0] p;
    logic [7:0] b;
    c = 1'($random(seed));
    p = 8'($random(seed));
    // Out of sync: pick the bit that would visibly change the held signaling
    if (l) p[0] = ~rs_exp[0];
    pat <= p;
    lost <= l;
    for (int k = 0; k < 3; k++) begin
      b = 8'($random(seed));
      wr(TS_BASE_IDX + 8'(k), b, 1'b0);
      ts_live[k*8 +: 8] = b;
    end
    wr(SIGCTL_IDX, {2'h0, f, 5'h00}, 1'b0);
    force_q = f;
    wr(CTL_IDX, {c, 2'h0, ch}, 1'b0);
    chk(32'(crc), 32'(c));
    rd(CTL_IDX, {c, 2'h0, ch}, 1'b0);
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    repeat (200) @(posedge pclk);
    if (ch < 5'd24) mon_exp = pat ^ {3'h0, ch};
    rd(MON_IDX, mon_exp, 1'b0);
    rd(RS_BASE_IDX, rs_exp, 1'b0);
    lost <= 1'b0;
  endtask : frame

  task automatic tally_and_finish();
    if (mismatches == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  // ****************
  // Main sequence
  // ****************
  initial begin
    {psel, penable, pwrite, go, sep_r, sep_t, force_q, presetn, lost} = 9'h000;
    paddr = 12'h000;
    pwdata = 32'h0;
    pat = 8'h00;
    mon_exp = MON_RST;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(CTL_IDX, CTL_RST, 1'b0);
    rd(MON_IDX, MON_RST, 1'b0);
    rd(SIGCTL_IDX, SIGCTL_RST, 1'b0);
    rd(8'h21, 8'h00, 1'b1);
    wr(8'h21, 8'h5a, 1'b1);
    wr(MON_IDX, 8'hff, 1'b0);
    rd(MON_IDX, MON_RST, 1'b0);
    wr(TS_BASE_IDX + 8'h0b, 8'ha5, 1'b0);
    rd(TS_BASE_IDX + 8'h0b, 8'ha5, 1'b0);
    wr(RS_BASE_IDX + 8'h0b, 8'hff, 1'b0);
    rd(RS_BASE_IDX + 8'h0b, 8'h00, 1'b0);
    align(8'h40, 1'b0, 1'b0, 1, 0);
    align(8'h40, 1'b0, 1'b0, 0, 0);
    align(8'h00, 1'b0, 1'b0, 0, 0);
    align(8'h40, 1'b1, 1'b0, 0, 0);
    align(8'h20, 1'b0, 1'b0, 0, 1);
    align(8'h00, 1'b0, 1'b0, 0, 0);
    align(8'h60, 1'b0, 1'b1, 1, 0);
    frame(5'd0, 1'b0, 1'b0);
    frame(5'd23, 1'b1, 1'b0);
    frame(5'd24, 1'b0, 1'b0);
    frame(5'd5, 1'b0, 1'b1);
    for (int i = 0; i < 4; i++) begin
      frame(5'($unsigned($random(seed)) % 24), 1'(i), 1'b0);
    end
    tally_and_finish();
  end

  // Cut a hang short well beyond the just under two thousand cycles the run needs
  initial begin
    repeat (50000) @(posedge pclk);
    mismatches++;
    tally_and_finish();
  end
endmodule : tb_t1_rx_monitor_align_signaling_ctl
`default_nettype wire
